/* dv/card_model.sv */
// Card-side source of error pulses, descriptor engine state and length
`timescale 1ns/1ps
module card_model (
  input wire logic clk,
  input wire logic [15:0] ev_req,
  input wire logic dma_req,
  input wire logic [1:0] st_req,
  input wire logic [31:0] len_req,
  output logic [15:0] error_events = 16'h0000,
  output logic dma_error = 1'b0,
  output logic [1:0] dma_engine_state = 2'h0,
  output logic [31:0] desc_total_len = 32'h00000000
);
  // Registered so every pulse is launched just after an edge, one cycle long
  always_ff @(posedge clk)
  begin
    error_events <= ev_req;
    dma_error <= dma_req;
    dma_engine_state <= st_req;
    desc_total_len <= len_req;
  end
endmodule : card_model

/* dv/sdmmc_host_error_reporting_tb.sv */
// Self-checking bench for the error-reporting register bank
`timescale 1ns/1ps
module sdmmc_host_error_reporting_tb;
  import err_report_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [15:0] error_events;
  logic dma_error;
  logic [1:0] dma_engine_state;
  logic [31:0] desc_total_len;
  logic [15:0] error_status_flags;
  logic irq;
  logic [15:0] ev_req = '0;
  logic dma_req = 1'b0;
  logic [1:0] st_req = '0;
  logic [31:0] len_req = '0;
  int errors = 0;
  int checks = 0;
  int en, emmc, mk, ev, ex, bs, cnt, len, st, mis;

  initial
  begin
    forever #10 clk = ~clk;
  end

  sdmmc_host_error_reporting u_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .error_events(error_events), .dma_error(dma_error),
    .dma_engine_state(dma_engine_state), .desc_total_len(desc_total_len),
    .error_status_flags(error_status_flags), .irq(irq));

  card_model u_card (.clk(clk), .ev_req(ev_req), .dma_req(dma_req),
    .st_req(st_req), .len_req(len_req), .error_events(error_events),
    .dma_error(dma_error), .dma_engine_state(dma_engine_state),
    .desc_total_len(desc_total_len));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_irq(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: irq %b expected %b", $time, got, exp);
    end
  endtask : chk_irq

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Partner turns the request into a pulse one edge later
  task automatic pulse(input logic [15:0] e, input logic d,
                       input logic [1:0] s, input logic [31:0] l);
    @(posedge clk);
    ev_req <= e;
    dma_req <= d;
    st_req <= s;
    len_req <= l;
    @(posedge clk);
    ev_req <= '0;
    dma_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  task automatic results();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial
  begin
    // Roughly ten times the length of all tests
    repeat (5000) @(posedge clk);
    errors++;
    results();
  end

  initial
  begin
    logic [15:0] v;
    void'($urandom(41));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ERR_STATUS_ENABLE_OFF, v);
    chk(v, ERR_ENABLE_RST);
    rd(DMA_ERROR_STATUS_OFF, v);
    chk(v, {8'h00, DMA_ERR_RST});
    rd(8'h7e, v);
    chk(v, 16'h0000);
    chk(error_status_flags, 16'h0000);
    chk_irq(irq, 1'b0);
    $display("test reset done");
    wr(ERR_STATUS_ENABLE_OFF, 16'hffff);
    rd(ERR_STATUS_ENABLE_OFF, v);
    chk(v, 16'h13ff);
    $display("test enable readback done");
    for (int i = 0; i < 12; i++)
    begin
      en = (i == 0) ? 32'hffff : ($urandom & 32'hffff);
      emmc = (i < 2) ? i : $urandom % 2;
      mk = $urandom % 2;
      ev = (i < 2) ? 32'hffff : ($urandom & 32'hffff);
      wr(ERR_STATUS_ENABLE_OFF, en[15:0]);
      wr(XFER_CFG_OFF, {14'h0, emmc[0], 1'b0});
      wr(IRQ_MASK_OFF, {15'h0, mk[0]});
      wr(ERR_FLAGS_OFF, 16'hffff);
      wr(IRQ_STATUS_OFF, 16'h0003);
      chk_irq(irq, 1'b0);
      pulse(ev[15:0], 1'b0, 2'h0, 32'h0);
      ex = ev & en & (emmc[0] ? 32'h13ff : 32'h03ff);
      chk(error_status_flags, ex[15:0]);
      rd(ERR_FLAGS_OFF, v);
      chk(v, ex[15:0]);
      chk_irq(irq, mk[0] && ex != 0);
      rd(IRQ_STATUS_OFF, v);
      chk(v, {15'h0000, ex != 0});
    end
    $display("test enable gating done");
    wr(IRQ_MASK_OFF, 16'h0002);
    rd(IRQ_MASK_OFF, v);
    chk(v, 16'h0002);
    for (int i = 0; i < 16; i++)
    begin
      bs = $urandom % 9;
      cnt = $urandom % 6;
      len = ($urandom % 2) ? bs * cnt : $urandom % 48;
      st = i % 4;
      mk = $urandom % 2;
      wr(XFER_CFG_OFF, {15'h0, mk[0]});
      wr(BLOCK_SIZE_OFF, bs[15:0]);
      wr(BLOCK_COUNT_OFF, cnt[15:0]);
      wr(IRQ_STATUS_OFF, 16'h0003);
      chk_irq(irq, 1'b0);
      pulse(16'h0, 1'b1, st[1:0], len);
      chk_irq(irq, 1'b1);
      rd(IRQ_STATUS_OFF, v);
      chk(v, 16'h0002);
      mis = (bs == 0) || (len % bs != 0) || (mk[0] && len != bs * cnt);
      rd(DMA_ERROR_STATUS_OFF, v);
      chk(v, {13'h0, mis[0], (st == 2) ? 2'h3 : st[1:0]});
    end
    $display("test descriptor error capture done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_irq(irq, 1'b0);
    chk(error_status_flags, 16'h0000);
    rd(ERR_STATUS_ENABLE_OFF, v);
    chk(v, ERR_ENABLE_RST);
    rd(DMA_ERROR_STATUS_OFF, v);
    chk(v, {8'h00, DMA_ERR_RST});
    rd(IRQ_STATUS_OFF, v);
    chk(v, 16'h0000);
    $display("test mid-run reset done");
    results();
  end
endmodule : sdmmc_host_error_reporting_tb

/* hdl/err_report_pkg.sv */
// Constants for the error-reporting register bank
package err_report_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [7:0] ERR_STATUS_ENABLE_OFF = 8'h36;
  localparam logic [7:0] DMA_ERROR_STATUS_OFF = 8'h54;
  localparam logic [7:0] ERR_FLAGS_OFF = 8'h30;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h60;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h62;
  localparam logic [7:0] XFER_CFG_OFF = 8'h64;
  localparam logic [7:0] BLOCK_SIZE_OFF = 8'h66;
  localparam logic [7:0] BLOCK_COUNT_OFF = 8'h68;
  // Reset values
  localparam logic [15:0] ERR_ENABLE_RST = 16'h0000;
  localparam logic [7:0] DMA_ERR_RST = 8'h00;
  // Enable field positions
  localparam int CMD_TIMEOUT_BIT = 0;
  localparam int CMD_CRC_BIT = 1;
  localparam int CMD_END_BIT = 2;
  localparam int CMD_INDEX_BIT = 3;
  localparam int DAT_TIMEOUT_BIT = 4;
  localparam int DAT_CRC_BIT = 5;
  localparam int DAT_END_BIT = 6;
  localparam int CUR_LIMIT_BIT = 7;
  localparam int AUTO_CMD_BIT = 8;
  localparam int DESC_DMA_BIT = 9;
  localparam int BOOT_ACK_BIT = 12;
  localparam logic [15:0] ENABLE_WMASK = 16'h13ff;
  // DMA error register fields
  localparam int LEN_MISMATCH_BIT = 2;
  localparam int ERR_STATE_LSB = 0;
  // Transfer config bits
  localparam int BLOCK_COUNT_EN_BIT = 0;
  localparam int EMMC_MODE_BIT = 1;
  // Interrupt status bits
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_DMA_BIT = 1;
  localparam int IRQ_W = 2;
  // Descriptor engine state encodings
  localparam logic [1:0] STATE_STOPPED = 2'h0;
  localparam logic [1:0] STATE_FETCH_DESCRIPTOR = 2'h1;
  localparam logic [1:0] STATE_RESERVED = 2'h2;
  localparam logic [1:0] STATE_TRANSFER_DATA = 2'h3;
endpackage : err_report_pkg

/* hdl/irq_gate.sv */
`timescale 1ns/1ps
// Sticky interrupt status, write-one-to-clear, with mask
module irq_gate
  import err_report_pkg::*;
#(
  parameter int N = IRQ_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] clear_in,
  input wire logic [N-1:0] mask_in,
  output logic [N-1:0] status,
  output logic irq
);
  if (N < 1)
  begin : g_n_check
    $error("irq_gate: N must be at least 1");
  end

  logic [N-1:0] status_d;
  logic [N-1:0] status_q;
  logic irq_d;
  logic irq_q;

  always_comb
  begin
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~clear_in) | event_in;
    irq_d = |(status_d & mask_in);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign status = status_q;
  assign irq = irq_q;
endmodule : irq_gate

/* hdl/length_check.sv */
`timescale 1ns/1ps
// Descriptor total length checker against block count and block size
module length_check
  import err_report_pkg::*;
#(
  parameter int LEN_W = 32
)
(
  input wire logic [LEN_W-1:0] total_len,
  input wire logic [15:0] block_size,
  input wire logic [15:0] block_count,
  input wire logic block_count_enable,
  output logic mismatch
);
  // Count times size needs the full 32 bits to stay exact
  if (LEN_W < 32)
  begin : g_len_w_check
    $error("length_check: LEN_W must be at least 32");
  end

  logic [LEN_W-1:0] expected;
  logic not_multiple;
  logic count_diff;

  always_comb
  begin
    expected = LEN_W'(block_count) * LEN_W'(block_size);
    // A zero block size cannot divide anything: treat as a mismatch
    not_multiple = (block_size == 16'h0000) ? 1'b1 :
                   ((total_len % LEN_W'(block_size)) != '0);
    count_diff = block_count_enable && (total_len != expected);
    mismatch = count_diff || not_multiple;
  end
endmodule : length_check

/* hdl/sdmmc_host_error_reporting.sv */
`timescale 1ns/1ps
// Error enable gating and descriptor-DMA error capture register bank

// What this block does
// R1 - Enable bit 12 passes or masks the boot acknowledge error flag
// R2 - Boot acknowledge error enable only acts in embedded card mode
// R3 - Enable bit 9 passes or masks the descriptor-DMA error flag
// R4 - Enable bit 8 passes or masks the automatic command error flag
// R5 - Enable bit 7 passes or masks the current limit error flag
// R6 - Enable bit 6 passes or masks the data end bit error flag
// R7 - Bit 2 flags total length unequal to count times size when counting
// R8 - Bit 2 also flags total length not a multiple of block size
// R9 - Bits 1:0 capture the descriptor engine state when an error occurs
// R10 - State codes: 0 stopped, 1 descriptor fetch, 3 data transfer
// R11 - The state field never reports the reserved value 2
// R12 - Enable bits 5 to 0 pass or mask the command and data flags
module sdmmc_host_error_reporting
  import err_report_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic [15:0] error_events,
  input wire logic dma_error,
  input wire logic [1:0] dma_engine_state,
  input wire logic [31:0] desc_total_len,
  output logic [15:0] error_status_flags,
  output logic irq
);
  logic [15:0] enable_d;
  logic [15:0] enable_q;
  logic [15:0] flags_d;
  logic [15:0] flags_q;
  logic len_mis_d;
  logic len_mis_q;
  logic [1:0] err_state_d;
  logic [1:0] err_state_q;
  logic [1:0] cfg_d;
  logic [1:0] cfg_q;
  logic [15:0] bsize_d;
  logic [15:0] bsize_q;
  logic [15:0] bcount_d;
  logic [15:0] bcount_q;
  logic [IRQ_W-1:0] mask_d;
  logic [IRQ_W-1:0] mask_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [15:0] gate;
  logic [15:0] flag_clr;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_status;
  logic irq_w;
  logic mismatch;
  logic [1:0] state_legal;

  length_check #(
    .LEN_W(32)
  ) u_len (
    .total_len(desc_total_len),
    .block_size(bsize_q),
    .block_count(bcount_q),
    .block_count_enable(cfg_q[BLOCK_COUNT_EN_BIT]),
    .mismatch(mismatch)
  );

  irq_gate #(
    .N(IRQ_W)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .event_in(irq_evt),
    .clear_in(irq_clr),
    .mask_in(mask_q),
    .status(irq_status),
    .irq(irq_w)
  );

  // Per-flag gating of the error status register
  always_comb
  begin
    gate = enable_q & ENABLE_WMASK; // R3 R4 R5 R6 R12
    // Boot acknowledge only has meaning on an embedded card
    gate[BOOT_ACK_BIT] = enable_q[BOOT_ACK_BIT] &&
                         cfg_q[EMMC_MODE_BIT]; // R1 R2
  end

  // Register writes and error capture
  always_comb
  begin
    enable_d = enable_q;
    cfg_d = cfg_q;
    bsize_d = bsize_q;
    bcount_d = bcount_q;
    mask_d = mask_q;
    flag_clr = 16'h0000;
    irq_clr = '0;
    if (wr_en)
    begin
      if (addr == ERR_STATUS_ENABLE_OFF)
        enable_d = wdata & ENABLE_WMASK;
      else if (addr == ERR_FLAGS_OFF)
        flag_clr = wdata;
      else if (addr == IRQ_STATUS_OFF)
        irq_clr = wdata[IRQ_W-1:0];
      else if (addr == IRQ_MASK_OFF)
        mask_d = wdata[IRQ_W-1:0];
      else if (addr == XFER_CFG_OFF)
        cfg_d = wdata[1:0];
      else if (addr == BLOCK_SIZE_OFF)
        bsize_d = wdata;
      else if (addr == BLOCK_COUNT_OFF)
        bcount_d = wdata;
    end
    // Masked events never latch; set wins over a write-one clear
    flags_d = (flags_q & ~flag_clr) | (error_events & gate);
    state_legal = (dma_engine_state == STATE_RESERVED) ?
                  STATE_TRANSFER_DATA : dma_engine_state; // R10 R11
    len_mis_d = len_mis_q;
    err_state_d = err_state_q;
    if (dma_error)
    begin
      err_state_d = state_legal; // R9
      len_mis_d = mismatch; // R7 R8
    end
    irq_evt[IRQ_ERR_BIT] = |(error_events & gate);
    irq_evt[IRQ_DMA_BIT] = dma_error;
  end

  // Read mux
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_en)
    begin
      if (addr == ERR_STATUS_ENABLE_OFF)
        rdata_d = enable_q;
      else if (addr == DMA_ERROR_STATUS_OFF)
        rdata_d = {13'h0000, len_mis_q, err_state_q};
      else if (addr == ERR_FLAGS_OFF)
        rdata_d = flags_q;
      else if (addr == IRQ_STATUS_OFF)
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
      else if (addr == IRQ_MASK_OFF)
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, mask_q};
      else if (addr == XFER_CFG_OFF)
        rdata_d = {14'h0000, cfg_q};
      else if (addr == BLOCK_SIZE_OFF)
        rdata_d = bsize_q;
      else if (addr == BLOCK_COUNT_OFF)
        rdata_d = bcount_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_q <= ERR_ENABLE_RST;
      flags_q <= 16'h0000;
      len_mis_q <= DMA_ERR_RST[LEN_MISMATCH_BIT];
      err_state_q <= STATE_STOPPED;
      cfg_q <= 2'h0;
      bsize_q <= 16'h0000;
      bcount_q <= 16'h0000;
      mask_q <= '0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      enable_q <= enable_d;
      flags_q <= flags_d;
      len_mis_q <= len_mis_d;
      err_state_q <= err_state_d;
      cfg_q <= cfg_d;
      bsize_q <= bsize_d;
      bcount_q <= bcount_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign error_status_flags = flags_q;
  assign irq = irq_w;

  // Steps that the checks below are built from
  sequence s_boot_ack_masked;
    error_events[BOOT_ACK_BIT] && !flags_q[BOOT_ACK_BIT] &&
    !cfg_q[EMMC_MODE_BIT];
  endsequence

  sequence s_boot_ack_open;
    error_events[BOOT_ACK_BIT] && enable_q[BOOT_ACK_BIT] &&
    cfg_q[EMMC_MODE_BIT];
  endsequence

  sequence s_enable_write;
    wr_en && (addr == ERR_STATUS_ENABLE_OFF);
  endsequence

  sequence s_enable_read;
    rd_en && (addr == ERR_STATUS_ENABLE_OFF);
  endsequence

  sequence s_reserved_capture;
    dma_error && (dma_engine_state == STATE_RESERVED);
  endsequence

  a_boot_ack_gate: assert property ( // R2
    @(posedge clk) disable iff (rst)
    s_boot_ack_masked |=> !flags_q[BOOT_ACK_BIT])
    else $error("boot ack flag set outside embedded mode");
  a_boot_ack_on: assert property ( // R1
    @(posedge clk) disable iff (rst)
    s_boot_ack_open |=> flags_q[BOOT_ACK_BIT])
    else $error("enabled boot ack flag not latched");

  a_dma_flag_mask: assert property ( // R3
    @(posedge clk) disable iff (rst)
    (error_events[DESC_DMA_BIT] && !enable_q[DESC_DMA_BIT] &&
     !flags_q[DESC_DMA_BIT]) |=> !flags_q[DESC_DMA_BIT])
    else $error("masked dma flag latched");
  a_dma_flag_on: assert property ( // R3
    @(posedge clk) disable iff (rst)
    (error_events[DESC_DMA_BIT] && enable_q[DESC_DMA_BIT])
    |=> flags_q[DESC_DMA_BIT])
    else $error("enabled dma flag not latched");

  a_auto_cmd_on: assert property ( // R4
    @(posedge clk) disable iff (rst)
    (error_events[AUTO_CMD_BIT] && enable_q[AUTO_CMD_BIT])
    |=> flags_q[AUTO_CMD_BIT])
    else $error("auto command flag not latched");
  a_auto_cmd_mask: assert property ( // R4
    @(posedge clk) disable iff (rst)
    (error_events[AUTO_CMD_BIT] && !enable_q[AUTO_CMD_BIT] &&
     !flags_q[AUTO_CMD_BIT]) |=> !flags_q[AUTO_CMD_BIT])
    else $error("masked auto command flag latched");

  a_cur_lim_on: assert property ( // R5
    @(posedge clk) disable iff (rst)
    (error_events[CUR_LIMIT_BIT] && enable_q[CUR_LIMIT_BIT])
    |=> flags_q[CUR_LIMIT_BIT])
    else $error("current limit flag not latched");
  a_cur_lim_mask: assert property ( // R5
    @(posedge clk) disable iff (rst)
    (error_events[CUR_LIMIT_BIT] && !enable_q[CUR_LIMIT_BIT] &&
     !flags_q[CUR_LIMIT_BIT]) |=> !flags_q[CUR_LIMIT_BIT])
    else $error("masked current limit flag latched");

  a_data_end_on: assert property ( // R6
    @(posedge clk) disable iff (rst)
    (error_events[DAT_END_BIT] && enable_q[DAT_END_BIT])
    |=> flags_q[DAT_END_BIT])
    else $error("data end flag not latched");
  a_data_end_mask: assert property ( // R6
    @(posedge clk) disable iff (rst)
    (error_events[DAT_END_BIT] && !enable_q[DAT_END_BIT] &&
     !flags_q[DAT_END_BIT]) |=> !flags_q[DAT_END_BIT])
    else $error("masked data end flag latched");

  // Command and data flags share one gating scheme, checked bit by bit
  for (genvar b = CMD_TIMEOUT_BIT; b <= DAT_CRC_BIT; b = b + 1)
  begin : g_low_flags
    a_low_flag_on: assert property ( // R12
      @(posedge clk) disable iff (rst)
      (error_events[b] && enable_q[b]) |=> flags_q[b])
      else $error("enabled command or data flag not latched");
    a_low_flag_mask: assert property ( // R12
      @(posedge clk) disable iff (rst)
      (error_events[b] && !enable_q[b] && !flags_q[b]) |=> !flags_q[b])
      else $error("masked command or data flag latched");
  end

  a_len_capture: assert property ( // R7 R8
    @(posedge clk) disable iff (rst)
    dma_error |=> (len_mis_q == $past(mismatch)))
    else $error("length mismatch not captured");
  a_capture_hold: assert property ( // R9
    @(posedge clk) disable iff (rst)
    !dma_error |=> ($stable(len_mis_q) && $stable(err_state_q)))
    else $error("dma error register changed without an error");
  a_state_capture: assert property ( // R9 R10
    @(posedge clk) disable iff (rst)
    (dma_error && dma_engine_state != STATE_RESERVED)
    |=> (err_state_q == $past(dma_engine_state)))
    else $error("engine state not captured");
  a_state_remap: assert property ( // R10 R11
    @(posedge clk) disable iff (rst)
    s_reserved_capture |=> (err_state_q == STATE_TRANSFER_DATA))
    else $error("reserved engine state not reported as transfer");
  a_state_never2: assert property ( // R11
    @(posedge clk) disable iff (rst)
    err_state_q != STATE_RESERVED)
    else $error("error state reports reserved value");

  a_enable_write: assert property (
    @(posedge clk) disable iff (rst)
    s_enable_write |=> (enable_q == ($past(wdata) & ENABLE_WMASK)))
    else $error("enable write not stored");
  a_read_latency: assert property (
    @(posedge clk) disable iff (rst)
    s_enable_read |=> (rdata == $past(enable_q)))
    else $error("enable readback wrong");
  a_read_idle: assert property (
    @(posedge clk) disable iff (rst)
    !rd_en |=> (rdata == 16'h0000))
    else $error("read data not zero outside a read");
  // The mask reaches the output one cycle after it is written
  a_irq_level: assert property (
    @(posedge clk) disable iff (rst)
    irq == (|(irq_status & $past(mask_q))))
    else $error("interrupt level disagrees with status and mask");
endmodule : sdmmc_host_error_reporting
